/* File: bench/lcsc_top_bench.sv */
// Purpose: Self-checking bench for the link control set/clear bank
// Assumes: Design assertions live in the design files
// Notes: Reset readback and table rows first, then lock, receive, timer and mid-run reset cases
`timescale 1ns/100ps
module lcsc_top_bench;
    import lcsc_pkg::*;
    // ======================================================
    // Row type: write, then read back
    typedef struct packed {
        logic [7:0] wa; // Write address
        logic [31:0] wd; // Write data
        logic [7:0] ra; // Read address
        logic [31:0] ex; // Expected read
    } lcsc_row_t;
    // ======================================================
    // Signals
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic exp_rst = 1'b0; // Express reset source
    logic glob_rst = 1'b0; // Global reset source
    logic overlong = 1'b0; // Overlong cycle level
    logic ext_cyc = 1'b0; // External rollover input
    logic filt_wr = 1'b0; // Software match bit value
    lcsc_rx_t rx = '0;
    lcsc_rx_acc_t acc;
    logic tag, emit, src, root, cnt, phy, sid, lock;
    logic [11:0] ofs;
    logic [31:0] d;
    logic [11:0] held;
    int fails = 0;
    int compares = 0;
    int n;
    int emits = 0;
    lcsc_row_t rows [8] = '{
        '{8'hE0, 32'hFFFF_FFFF, 8'hE4, 32'h0070_0640},
        '{8'hE4, 32'hFFFF_FFFF, 8'hE0, 32'h0000_0040},
        '{8'hE0, 32'h0010_0000, 8'hE0, 32'h0010_0040},
        '{8'hE4, 32'h0000_0000, 8'hE4, 32'h0010_0040},
        '{8'hE0, 32'h0000_0600, 8'hE0, 32'h0010_0640},
        '{8'hE4, 32'h0000_0200, 8'hE0, 32'h0010_0440},
        '{8'hF0, 32'hFFFF_FFFF, 8'hE0, 32'h0010_0440},
        '{8'hE8, 32'h0000_0000, 8'hE8, 32'h0000_0000}};

    // Clock, 8 ns period
    always #4 clk = ~clk;

    // Count cycle start pulses
    always @(posedge clk) begin
        if (emit === 1'b1) begin
            emits++;
        end
    end

    lcsc_top uut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .express_fundamental_reset_in(exp_rst),
        .global_reset_input(glob_rst), .overlong_cycle_event(overlong),
        .external_cycle_input(ext_cyc), .rx_in(rx),
        .tag_one_sync_filter_wr(filt_wr), .rx_acc(acc),
        .tag_one_sync_filter(tag), .cycle_offset(ofs),
        .cycle_start_emit(emit), .rollover_source_select(src),
        .root_cycle_generator_enable(root),
        .timer_offset_count_enable(cnt),
        .phy_packet_receive_enable(phy),
        .self_identification_receive_enable(sid),
        .sync_filter_force_lock(lock));

    // ======================================================
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] ex);
        compares++;
        if (seen !== ex) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, ex);
        end
    endtask

    task automatic end_of_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // One write cycle, flags settled when it returns
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // One read cycle; data taken in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // Bounded wait for a cycle start pulse
    task automatic wait_emit(input int lim);
        n = 0;
        while (emit !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= lim) begin
            fails++;
            end_of_test();
        end
    endtask

    // Pulse one of the two extra flag reset sources
    task automatic pulse_src(input int j);
        @(posedge clk);
        if (j == 0) begin
            glob_rst <= 1'b1;
        end else begin
            exp_rst <= 1'b1;
        end
        @(posedge clk);
        glob_rst <= 1'b0;
        exp_rst <= 1'b0;
        #1;
    endtask

    // ======================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(8'hE0, d);
        chk(d, 32'h0000_0000);
        @(posedge clk);
        #1 chk(reg_rdata, 32'h0000_0000);
        // Table of set/clear accesses
        foreach (rows[i]) begin
            wr(rows[i].wa, rows[i].wd);
            rd(rows[i].ra, d);
            chk(d, rows[i].ex);
        end
        chk(32'({src, root, cnt, phy, sid, lock}), 32'h0000_000D);
        // Lock forces the filter bit; global and express resets each clear it
        #1 chk(32'(tag), 32'h1);
        for (int j = 0; j < 2; j++) begin
            wr(8'hE0, 32'h0000_0040);
            pulse_src(j);
            chk(32'(lock), 32'h0);
        end
        @(posedge clk);
        filt_wr <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk(32'(tag), 32'h1);
        @(posedge clk);
        filt_wr <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(32'(tag), 32'h0);
        // All gating combinations of the receive path
        for (int i = 0; i < 8; i++) begin
            wr(8'hE4, 32'h0000_0600);
            wr(8'hE0, {21'h0, i[2], i[0], 9'h0});
            @(posedge clk);
            rx.ar_req_ctx_en <= i[1];
            rx.phy_pkt <= 1'b1;
            rx.self_id_pkt <= 1'b1;
            @(posedge clk);
            rx.phy_pkt <= 1'b0;
            rx.self_id_pkt <= 1'b0;
            #1 chk(32'(acc.phy_deliver), 32'(i[2] & i[1]));
            chk(32'(acc.self_id_accept), 32'(i[0]));
        end
        // Internal rollover period as root
        wr(8'hE4, 32'hFFFF_FFFF);
        wr(8'hE0, 32'h0030_0000);
        wait_emit(20000);
        @(posedge clk);
        #1 wait_emit(20000);
        chk(32'(n >= 15623 && n <= 15625), 32'h1);
        chk(32'(ofs), 32'h0);
        // Count enable low holds the offset
        wr(8'hE4, 32'h0010_0000);
        #1 held = ofs;
        chk(32'(cnt), 32'h0);
        repeat (200) @(posedge clk);
        #1 chk(32'(ofs), 32'(held));
        // Overlong event clears root and blocks setting it
        @(posedge clk);
        overlong <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk(32'(root), 32'h0);
        wr(8'hE0, 32'h0020_0000);
        #1 chk(32'(root), 32'h0);
        @(posedge clk);
        overlong <= 1'b0;
        wr(8'hE0, 32'h0020_0000);
        #1 chk(32'(root), 32'h1);
        // External source: no internal rollover, edge rolls over
        wr(8'hE0, 32'h0050_0000);
        #1 chk(32'({src, root, cnt}), 32'h7);
        held = 12'(emits);
        repeat (17000) @(posedge clk);
        #1 chk(32'(emits), 32'(held));
        chk(32'(ofs), 32'(LCSC_OFS_LAST));
        @(posedge clk);
        ext_cyc <= 1'b1;
        #1 wait_emit(8);
        chk(32'(ofs), 32'h0);
        @(posedge clk);
        ext_cyc <= 1'b0;
        // Non-root follows a received cycle start
        wr(8'hE4, 32'h0060_0000);
        @(posedge clk);
        rx.cycle_start_ofs <= 12'h123;
        rx.cycle_start_pkt <= 1'b1;
        @(posedge clk);
        rx.cycle_start_pkt <= 1'b0;
        #1 chk(32'(ofs == 12'h123 || ofs == 12'h124), 32'h1);
        // Second reset in mid-run clears every flag
        wr(8'hE0, 32'hFFFF_FFFF);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rd(8'hE4, d);
        chk(d, 32'h0000_0000);
        end_of_test();
    end
endmodule

/* File: hdl/lcsc_pkg.sv */
// Purpose: Constants and carriers for the link control set/clear bank
// Assumes: 125 MHz core clock, byte addresses on the register port
// Notes: Operation summary of the bank follows
// Operation
// - Flags reachable at a set and clear offset
// - Reserved bit ranges always read as zero
// - Source flag selects external cycle input rollover
// - Otherwise roll over after 3072 timer counts
// - Root flag emits cycle start each rollover
// - Non-root follows received cycle start packets
// - Overlong cycle event clears root flag
// - Root set ignored while overlong event stands
// - Count enable advances offset on each tick below the last count
// - Count enable low holds the offset
// - PHY packets delivered only if context enabled
// - PHY flag never affects self-ID receipt
// - Self-ID flag lets self-ID packets in
// - Lock forces tag-one sync filter to one
// - Unlocked filter bit freely readable and writable
// - Lock cleared only by the three resets
package lcsc_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] LCSC_SET_OFS = 8'hE0; // Set view
    localparam logic [7:0] LCSC_CLR_OFS = 8'hE4; // Clear view

    // ==========================================================
    // Flag positions
    localparam int LCSC_SRC_BIT = 22; // Rollover source
    localparam int LCSC_ROOT_BIT = 21; // Root generator
    localparam int LCSC_CNT_BIT = 20; // Count enable
    localparam int LCSC_PHY_BIT = 10; // PHY packet receive
    localparam int LCSC_SID_BIT = 9; // Self-ID receive
    localparam int LCSC_LOCK_BIT = 6; // Sync filter lock
    // Implemented bits; everything else reads zero
    localparam logic [31:0] LCSC_IMPL_MASK = 32'h0070_0640;
    localparam logic [31:0] LCSC_FLAGS_RST = 32'h0000_0000;

    // ==========================================================
    // Timing
    localparam int LCSC_CLK_KHZ = 125000; // Core clock rate
    localparam int LCSC_TMR_KHZ = 24576; // Cycle timer rate
    localparam int LCSC_CYCLE_US = 125; // Nominal cycle length
    localparam logic [11:0] LCSC_CYCLE_COUNTS =
        12'(LCSC_TMR_KHZ * LCSC_CYCLE_US / 1000); // 3072
    localparam logic [11:0] LCSC_OFS_LAST =
        LCSC_CYCLE_COUNTS - 12'h001;
    localparam logic [17:0] LCSC_ACC_STEP = 18'(LCSC_TMR_KHZ);
    localparam logic [17:0] LCSC_ACC_WRAP = 18'(LCSC_CLK_KHZ);

    // ==========================================================
    // Receive side carriers
    typedef struct packed {
        logic cycle_start_pkt; // Cycle start packet seen
        logic [11:0] cycle_start_ofs; // Its offset field
        logic phy_pkt; // Incoming PHY packet
        logic self_id_pkt; // Incoming self-ID packet
        logic ar_req_ctx_en; // Async receive request running
    } lcsc_rx_t;

    typedef struct packed {
        logic phy_deliver; // PHY packet into async receive
        logic self_id_accept; // Self-ID packet taken
    } lcsc_rx_acc_t;

endpackage

/* File: hdl/lcsc_top.sv */
// Purpose: Link control set/clear flags and cycle timer
// Assumes: All inputs synchronous to clk, rst synchronous high
// Notes: Read data valid only in the cycle after the strobe
`timescale 1ns/100ps
module lcsc_top #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Extra reset sources
    input wire logic express_fundamental_reset_in,
    input wire logic global_reset_input,
    // Link side
    input wire logic overlong_cycle_event,
    input wire logic external_cycle_input,
    input wire lcsc_pkg::lcsc_rx_t rx_in,
    input wire logic tag_one_sync_filter_wr,
    output lcsc_pkg::lcsc_rx_acc_t rx_acc,
    output logic tag_one_sync_filter,
    output logic [11:0] cycle_offset,
    output logic cycle_start_emit,
    output logic rollover_source_select,
    output logic root_cycle_generator_enable,
    output logic timer_offset_count_enable,
    output logic phy_packet_receive_enable,
    output logic self_identification_receive_enable,
    output logic sync_filter_force_lock
);
    import lcsc_pkg::*;

    // ==========================================================
    // Helpers
    // Address match against a register offset
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] ofs);
        hit = (a == ADDR_W'(ofs));
    endfunction

    // ==========================================================
    // Declarations
    logic [31:0] flags_reg; // Flag store
    logic [31:0] flags_next; // Flag next value
    logic [31:0] rdata_reg; // Read answer
    logic [17:0] acc_reg; // Tick phase accumulator
    logic [17:0] acc_sum; // Accumulator plus step
    logic tick_reg; // 24.576 MHz enable pulse
    logic ext_prev_reg; // Last external cycle level
    logic ext_edge; // External cycle rising edge
    logic [11:0] ofs_reg; // Cycle timer offset
    logic roll; // Rollover this cycle
    logic start_reg; // Cycle start pulse
    logic filt_reg; // Effective sync filter bit
    lcsc_rx_acc_t acc_out_reg; // Receive acceptance
    logic set_wr; // Write at set view
    logic clr_wr; // Write at clear view
    logic flag_rst; // Any flag reset source
    logic [31:0] set_mask; // Bits that may be set now

    // ==========================================================
    // Write decode
    // Strobes qualified by the two views
    assign set_wr = reg_wr && hit(reg_addr, LCSC_SET_OFS);
    assign clr_wr = reg_wr && hit(reg_addr, LCSC_CLR_OFS);
    // Power-on, fundamental and global reset all clear flags
    assign flag_rst = rst || express_fundamental_reset_in ||
                      global_reset_input;

    // Root cannot be set while the overlong event stands
    always_comb begin
        set_mask = LCSC_IMPL_MASK;
        if (overlong_cycle_event) begin
            set_mask[LCSC_ROOT_BIT] = 1'b0;
        end
    end

    // Next flag value from set/clear writes and hardware
    always_comb begin
        flags_next = flags_reg;
        if (set_wr) begin
            // Ones set, zeros leave alone
            flags_next = flags_reg | (reg_wdata & set_mask);
        end else if (clr_wr) begin
            // Ones clear; lock cannot be cleared here
            flags_next = flags_reg &
                ~(reg_wdata & LCSC_IMPL_MASK);
            flags_next[LCSC_LOCK_BIT] =
                flags_reg[LCSC_LOCK_BIT];
        end
        if (overlong_cycle_event) begin
            // Hardware drops the root role
            flags_next[LCSC_ROOT_BIT] = 1'b0;
        end
        // Reserved bits never hold a one
        flags_next = flags_next & LCSC_IMPL_MASK;
    end

    // ==========================================================
    // Flag store
    // All flags, lock included, cleared by the reset sources
    always_ff @(posedge clk) begin
        if (flag_rst) begin
            flags_reg <= LCSC_FLAGS_RST;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // ==========================================================
    // Read port
    // Either view returns the current flags, one cycle later
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_reg <= 32'h0000_0000;
        end else if (reg_rd && (hit(reg_addr, LCSC_SET_OFS) ||
                               hit(reg_addr, LCSC_CLR_OFS))) begin
            rdata_reg <= flags_reg & LCSC_IMPL_MASK;
        end else begin
            // Unmapped or idle cycles answer zero
            rdata_reg <= 32'h0000_0000;
        end
    end

    // ==========================================================
    // Timer tick divider
    // Fractional accumulator gives 24.576 MHz on average
    assign acc_sum = acc_reg + LCSC_ACC_STEP;

    always_ff @(posedge clk) begin
        if (rst) begin
            acc_reg <= 18'h0_0000;
            tick_reg <= 1'b0;
        end else if (acc_sum >= LCSC_ACC_WRAP) begin
            // Wrap and emit one enable pulse
            acc_reg <= acc_sum - LCSC_ACC_WRAP;
            tick_reg <= 1'b1;
        end else begin
            acc_reg <= acc_sum;
            tick_reg <= 1'b0;
        end
    end

    // ==========================================================
    // External cycle edge
    // Rising edge of the external cycle input
    always_ff @(posedge clk) begin
        if (rst) begin
            ext_prev_reg <= 1'b0;
        end else begin
            ext_prev_reg <= external_cycle_input;
        end
    end

    assign ext_edge = external_cycle_input && !ext_prev_reg;

    // ==========================================================
    // Rollover decision
    // Source flag picks external edge or internal count
    always_comb begin
        roll = 1'b0;
        if (flags_reg[LCSC_CNT_BIT]) begin
            if (flags_reg[LCSC_SRC_BIT]) begin
                roll = ext_edge;
            end else begin
                roll = tick_reg &&
                       (ofs_reg == LCSC_OFS_LAST);
            end
        end
    end

    // ==========================================================
    // Cycle timer offset
    // Counts ticks while enabled, holds otherwise
    always_ff @(posedge clk) begin
        if (rst) begin
            ofs_reg <= 12'h000;
        end else if (!flags_reg[LCSC_CNT_BIT]) begin
            ofs_reg <= ofs_reg;
        end else if (roll) begin
            ofs_reg <= 12'h000;
        end else if (!flags_reg[LCSC_ROOT_BIT] &&
                     rx_in.cycle_start_pkt) begin
            // Follow the sending root's offset
            ofs_reg <= rx_in.cycle_start_ofs;
        end else if (tick_reg &&
                     (ofs_reg != LCSC_OFS_LAST)) begin
            // Advance on each tick below the last count; at the last count the external source holds
            ofs_reg <= ofs_reg + 12'h001;
        end
    end

    // ==========================================================
    // Cycle start generation
    // Root emits a start packet request on each rollover
    always_ff @(posedge clk) begin
        if (rst) begin
            start_reg <= 1'b0;
        end else begin
            start_reg <= roll && flags_reg[LCSC_ROOT_BIT];
        end
    end

    // ==========================================================
    // Receive gating
    // PHY flag only steers PHY packets; self-ID separate
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_out_reg <= '0;
        end else begin
            acc_out_reg.phy_deliver <= rx_in.phy_pkt &&
                flags_reg[LCSC_PHY_BIT] &&
                rx_in.ar_req_ctx_en;
            acc_out_reg.self_id_accept <= rx_in.self_id_pkt &&
                flags_reg[LCSC_SID_BIT];
        end
    end

    // ==========================================================
    // Sync filter force
    // Lock forces the bit, else the written value passes
    always_ff @(posedge clk) begin
        if (rst) begin
            filt_reg <= 1'b0;
        end else if (flags_reg[LCSC_LOCK_BIT]) begin
            filt_reg <= 1'b1;
        end else begin
            filt_reg <= tag_one_sync_filter_wr;
        end
    end

    // ==========================================================
    // Outputs
    assign reg_rdata = rdata_reg;
    assign rx_acc = acc_out_reg;
    assign tag_one_sync_filter = filt_reg;
    assign cycle_offset = ofs_reg;
    assign cycle_start_emit = start_reg;
    assign rollover_source_select = flags_reg[LCSC_SRC_BIT];
    assign root_cycle_generator_enable = flags_reg[LCSC_ROOT_BIT];
    assign timer_offset_count_enable = flags_reg[LCSC_CNT_BIT];
    assign phy_packet_receive_enable = flags_reg[LCSC_PHY_BIT];
    assign self_identification_receive_enable =
        flags_reg[LCSC_SID_BIT];
    assign sync_filter_force_lock = flags_reg[LCSC_LOCK_BIT];

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Reserved bits of any read answer are zero
    AST_RSVD_ZERO: assert property (
        reg_rd |=> (reg_rdata & ~LCSC_IMPL_MASK) == 32'h0000_0000)
        else $error("Reserved bits read nonzero");

    // Set view write of source bit sets it, read shows it
    AST_SET_SRC: assert property (
        set_wr && reg_wdata[LCSC_SRC_BIT] && !flag_rst
        ##1 reg_rd && hit(reg_addr, LCSC_CLR_OFS) && !flag_rst
        |=> reg_rdata[LCSC_SRC_BIT])
        else $error("Set write not visible at clear view");

    // Clear view write clears count enable
    AST_CLR_CNT: assert property (
        clr_wr && reg_wdata[LCSC_CNT_BIT]
        |=> !timer_offset_count_enable)
        else $error("Clear write did not clear");

    // Overlong event removes and blocks the root flag
    AST_ROOT_DROP: assert property (
        overlong_cycle_event |=> !root_cycle_generator_enable)
        else $error("Root flag survived overlong event");

    AST_ROOT_BLOCK: assert property (
        overlong_cycle_event && set_wr &&
        reg_wdata[LCSC_ROOT_BIT] |=> !root_cycle_generator_enable)
        else $error("Root set while overlong event");

    // Internal rollover after the last of 3072 counts
    AST_INT_ROLL: assert property (
        timer_offset_count_enable && !rollover_source_select &&
        tick_reg && cycle_offset == 12'd3071 |=> cycle_offset == 0)
        else $error("Internal rollover missed");

    AST_EXT_ROLL: assert property (
        timer_offset_count_enable && rollover_source_select &&
        ext_edge |=> cycle_offset == 12'h000)
        else $error("External rollover missed");

    AST_HOLD: assert property (
        !timer_offset_count_enable |=> $stable(cycle_offset))
        else $error("Offset moved while disabled");

    AST_START: assert property (
        roll && root_cycle_generator_enable
        |=> cycle_start_emit ##1 !cycle_start_emit)
        else $error("Cycle start not emitted once");

    // Only the three reset sources may drop the lock
    AST_LOCK_KEEP: assert property (
        sync_filter_force_lock && !rst && !express_fundamental_reset_in &&
        !global_reset_input |=> sync_filter_force_lock)
        else $error("Lock cleared by software");

    // Reset clears the forced bit, so only outside reset
    AST_FORCE: assert property (
        sync_filter_force_lock && !rst |=> tag_one_sync_filter)
        else $error("Sync filter not forced");

    AST_PHY: assert property (
        rx_in.phy_pkt && !rx_in.ar_req_ctx_en |=> !rx_acc.phy_deliver)
        else $error("PHY packet with context stopped");

    AST_SID: assert property (
        rx_in.self_id_pkt && self_identification_receive_enable
        |=> rx_acc.self_id_accept)
        else $error("Self-ID packet refused");

    // Self-ID flag low refuses self-ID packets whatever PHY says
    AST_SID_GATE: assert property (
        rx_in.self_id_pkt && !self_identification_receive_enable
        |=> !rx_acc.self_id_accept)
        else $error("Self-ID packet taken while disabled");

    // Global or express reset clears every flag output
    AST_FLAG_RST: assert property (
        flag_rst |=> {rollover_source_select, root_cycle_generator_enable,
        timer_offset_count_enable, phy_packet_receive_enable,
        self_identification_receive_enable,
        sync_filter_force_lock} == 6'h00)
        else $error("Flags survived a reset source");

    // Read data answers zero outside the read slot
    AST_RD_IDLE: assert property (
        !reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("Read data outside its slot");

    // Unlocked filter bit follows the software value
    AST_FILT_FREE: assert property (
        !sync_filter_force_lock && !rst
        |=> tag_one_sync_filter == $past(tag_one_sync_filter_wr))
        else $error("Unlocked filter bit not writable");

    // Non-root loads the offset of a received cycle start
    AST_FOLLOW: assert property (
        timer_offset_count_enable && !root_cycle_generator_enable &&
        rx_in.cycle_start_pkt && !roll && !rst
        |=> cycle_offset == $past(rx_in.cycle_start_ofs))
        else $error("Received cycle start not followed");

    // No start request without a root rollover
    AST_NO_START: assert property (
        !(roll && root_cycle_generator_enable) |=> !cycle_start_emit)
        else $error("Cycle start without rollover");

    COV_ROLL_ROOT: cover property (roll && root_cycle_generator_enable);
    COV_EXT: cover property (rollover_source_select && roll);
    COV_INT: cover property (!rollover_source_select && roll);
    COV_LOCK: cover property (set_wr && reg_wdata[LCSC_LOCK_BIT]);
    COV_OVERLONG: cover property (
        root_cycle_generator_enable && overlong_cycle_event);
endmodule
